/* File: inc/fasm_pkg.sv */
package fasm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the serial register port
    localparam logic [5:0] FAULT_IRQ_MASK_OFS = 6'h1D;
    localparam logic [5:0] GENERAL_IRQ_MASK_OFS = 6'h1E;
    localparam logic [5:0] FAULT_FLAGS_OFS = 6'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] FAULT_IRQ_MASK_RST = 16'hEFDF;
    localparam logic [15:0] GENERAL_IRQ_MASK_RST = 16'hFFFF;
    localparam logic [15:0] FAULT_FLAGS_RST = 16'h0200;

    ////////////////////////////////////////////////////////////////////////////
    // Writable bits of each mask; the rest are reserved and read as ones
    localparam logic [15:0] FAULT_MASK_WR = 16'h31FF;
    localparam logic [15:0] GENERAL_MASK_WR = 16'h00CF;

    // Fault bits that feed the interrupt, and those that feed the alarm
    localparam logic [15:0] FAULT_IRQ_BITS = 16'h21FF;
    localparam logic [15:0] FAULT_ALARM_BITS = 16'h31FF;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the fault flag register
    localparam int GENERAL_SUMMARY_IRQ_POS = 15;
    localparam int SELF_DIAG_FAULT_POS = 13;
    localparam int OSCILLATOR_START_FAILURE_POS = 12;
    localparam int FRAME_CHECK_COUNTER_VIEW_LSB = 10;
    localparam int TRIM_NOT_LOADED_POS = 9;
    localparam int TRIM_CHECK_FAULT_POS = 8;
    localparam int FRAME_CHECK_FAULT_POS = 7;
    localparam int WATCHDOG_FAULT_FLAG_POS = 6;
    localparam int REFERENCE_INVALID_FAULT_POS = 5;
    localparam int INPUT_ONE_LIMIT_FAULT_POS = 4;
    localparam int INPUT_ZERO_LIMIT_FAULT_POS = 3;
    localparam int DIE_TEMP_LIMIT_FAULT_POS = 2;
    localparam int OVERTEMP_ERROR_POS = 1;
    localparam int OVERTEMP_WARNING_POS = 0;

    // Number of sticky flags and of analog detector inputs
    localparam int STICKY_COUNT = 3;
    localparam int ANALOG_COUNT = 3;

endpackage

/* File: logic/fasm_sticky.sv */
module fasm_sticky #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Causes, read strobe and held flags
    input wire logic [WIDTH-1:0] cause_i,
    input wire logic read_i,
    output logic [WIDTH-1:0] flag_o
);

    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    // Refused at elaboration: at least one flag is needed
    if (WIDTH < 1) begin : g_width_check
        $error("fasm_sticky: WIDTH must be at least 1");
    end

    // A live cause always wins over the read, so no event is lost
    always_comb begin
        flag_next = cause_i | (flag_reg & {WIDTH{~read_i}});
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg <= '0;
        end else if (ce_i) begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;

endmodule

/* File: logic/fasm_sync3.sv */
module fasm_sync3 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Asynchronous levels and their filtered copy
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;

    // Refused at elaboration: an empty chain has nothing to filter
    if (WIDTH < 1) begin : g_width_check
        $error("fasm_sync3: WIDTH must be at least 1");
    end

    // Three-stage chain; only the second stage reads the first
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else if (ce_i) begin
            meta_reg <= async_i;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A bit changes only once two settled stages agree, which rejects single-cycle glitches
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_reg <= '0;
        end else if (ce_i) begin
            level_reg <= (stage2_reg & stage3_reg) | (level_reg & (stage2_reg | stage3_reg));
        end
    end

    assign level_o = level_reg;

endmodule

/* File: logic/fasm_top.sv */
// How it works
// - Set mask bit blocks fault from IRQ, alarm, except bit 9
// - Flags set regardless of mask bits
// - Fault mask layout, reset EFDF, reserved ones
// - General mask layout, reset FFFF, reserved ones
// - Bit 15 ORs unmasked general status
// - Bit 13 shows self-diagnostic failure
// - Bit 12 oscillator failure: alarm, never IRQ
// - Bits 11-10 show frame-check counter view
// - Bit 9 trim-not-loaded holds alarm, resets one
// - Sticky bits clear on read once cause gone
// - Bit 8 trim memory check fault
// - Bit 7 frame check fault
// - Bit 6 watchdog fault flag
// - Bit 5 follows reference detector or force
// - Bits 4-2 converter limit faults
// - Bit 1 overtemp error level or force
// - Bit 0 overtemp warning level or force
// - Alarm summary ORs unmasked IRQ faults
module fasm_top (
    // Clock, reset and clock enable
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Register access from the serial interface
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Fault sources on this clock
    input wire logic self_diag_fault_i,
    input wire logic oscillator_start_failure_i,
    input wire logic [3:0] frame_check_count_i,
    input wire logic frame_check_limit_eight_i,
    input wire logic trim_load_done_i,
    input wire logic trim_check_error_i,
    input wire logic frame_check_error_i,
    input wire logic watchdog_error_i,
    input wire logic input_one_limit_i,
    input wire logic input_zero_limit_i,
    input wire logic die_temp_limit_i,
    // Analog detectors, asynchronous to this clock
    input wire logic reference_invalid_i,
    input wire logic overtemp_error_i,
    input wire logic overtemp_warning_i,
    // Forced-failure test bits
    input wire logic force_reference_i,
    input wire logic force_overtemp_error_i,
    input wire logic force_overtemp_warning_i,
    // General status flags, bits 7..0
    input wire logic [7:0] general_status_i,
    // Summary outputs
    output logic irq_o,
    output logic alarm_n_o,
    output logic alarm_summary_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [15:0] fault_irq_mask_reg;
    logic [15:0] general_irq_mask_reg;
    logic [15:0] fault_flags_reg;
    logic [15:0] fault_flags_next;
    logic trim_not_loaded_reg;
    logic [15:0] reg_rdata_reg;
    logic reg_rvalid_reg;
    logic irq_reg;
    logic alarm_n_reg;
    logic alarm_summary_reg;
    logic [fasm_pkg::ANALOG_COUNT-1:0] analog_level;
    logic [fasm_pkg::STICKY_COUNT-1:0] sticky_flag;
    logic fault_read;
    logic [1:0] frame_check_counter_view;
    logic general_summary_irq;
    logic fault_unmasked_irq;
    logic fault_unmasked_alarm;

    // Masked OR of a flag word, used for both summaries
    function automatic logic masked_any(input logic [15:0] flags, input logic [15:0] mask,
                                        input logic [15:0] sel);
        masked_any = |(flags & ~mask & sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning

    fasm_sync3 #(
        .WIDTH(fasm_pkg::ANALOG_COUNT)
    ) u_analog_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .async_i({reference_invalid_i, overtemp_error_i, overtemp_warning_i}),
        .level_o(analog_level)
    );

    assign fault_read = reg_rd_i && (reg_addr_i == fasm_pkg::FAULT_FLAGS_OFS);

    // Sticky flags keep their cause across reads while it persists
    fasm_sticky #(
        .WIDTH(fasm_pkg::STICKY_COUNT)
    ) u_sticky (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .cause_i({trim_check_error_i, frame_check_error_i, watchdog_error_i}),
        .read_i(fault_read),
        .flag_o(sticky_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mask registers

    // Only documented mask bits are writable; reserved bits stay at one
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_irq_mask_reg <= fasm_pkg::FAULT_IRQ_MASK_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == fasm_pkg::FAULT_IRQ_MASK_OFS) begin
            fault_irq_mask_reg <= (reg_wdata_i & fasm_pkg::FAULT_MASK_WR)
                                | ~fasm_pkg::FAULT_MASK_WR;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            general_irq_mask_reg <= fasm_pkg::GENERAL_IRQ_MASK_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == fasm_pkg::GENERAL_IRQ_MASK_OFS) begin
            general_irq_mask_reg <= (reg_wdata_i & fasm_pkg::GENERAL_MASK_WR)
                                  | ~fasm_pkg::GENERAL_MASK_WR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trim load tracking

    // Once trim memory has loaded the flag never returns until reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trim_not_loaded_reg <= 1'b1;
        end else if (ce_i && trim_load_done_i) begin
            trim_not_loaded_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault flag word

    // Limit of eight shows counter bits two and one, smaller limits the low pair
    assign frame_check_counter_view = frame_check_limit_eight_i
                                    ? frame_check_count_i[2:1]
                                    : frame_check_count_i[1:0];

    assign general_summary_irq = |(general_status_i & ~general_irq_mask_reg[7:0]);

    // Flags follow their causes whatever the masks say
    always_comb begin
        fault_flags_next = '0;
        fault_flags_next[fasm_pkg::GENERAL_SUMMARY_IRQ_POS] = general_summary_irq;
        fault_flags_next[fasm_pkg::SELF_DIAG_FAULT_POS] = self_diag_fault_i;
        fault_flags_next[fasm_pkg::OSCILLATOR_START_FAILURE_POS] =
            oscillator_start_failure_i;
        fault_flags_next[fasm_pkg::FRAME_CHECK_COUNTER_VIEW_LSB +: 2] =
            frame_check_counter_view;
        fault_flags_next[fasm_pkg::TRIM_NOT_LOADED_POS] = trim_not_loaded_reg;
        // Sticky bits take the held cell's next value, so the word never lags the cell
        // and a read clears only a flag that it has actually returned
        fault_flags_next[fasm_pkg::TRIM_CHECK_FAULT_POS] =
            trim_check_error_i | (sticky_flag[2] & ~fault_read);
        fault_flags_next[fasm_pkg::FRAME_CHECK_FAULT_POS] =
            frame_check_error_i | (sticky_flag[1] & ~fault_read);
        fault_flags_next[fasm_pkg::WATCHDOG_FAULT_FLAG_POS] =
            watchdog_error_i | (sticky_flag[0] & ~fault_read);
        fault_flags_next[fasm_pkg::REFERENCE_INVALID_FAULT_POS] =
            analog_level[2] | force_reference_i;
        fault_flags_next[fasm_pkg::INPUT_ONE_LIMIT_FAULT_POS] = input_one_limit_i;
        fault_flags_next[fasm_pkg::INPUT_ZERO_LIMIT_FAULT_POS] = input_zero_limit_i;
        fault_flags_next[fasm_pkg::DIE_TEMP_LIMIT_FAULT_POS] = die_temp_limit_i;
        fault_flags_next[fasm_pkg::OVERTEMP_ERROR_POS] =
            analog_level[1] | force_overtemp_error_i;
        fault_flags_next[fasm_pkg::OVERTEMP_WARNING_POS] =
            analog_level[0] | force_overtemp_warning_i;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_flags_reg <= fasm_pkg::FAULT_FLAGS_RST;
        end else if (ce_i) begin
            fault_flags_reg <= fault_flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summaries, interrupt and alarm

    assign fault_unmasked_irq = masked_any(fault_flags_reg, fault_irq_mask_reg,
                                           fasm_pkg::FAULT_IRQ_BITS);
    assign fault_unmasked_alarm = masked_any(fault_flags_reg, fault_irq_mask_reg,
                                             fasm_pkg::FAULT_ALARM_BITS);

    // The summary bit is already in the flag word, so the IRQ lags its cause by two cycles
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_reg <= 1'b0;
            alarm_summary_reg <= 1'b0;
        end else if (ce_i) begin
            irq_reg <= fault_unmasked_irq
                     | fault_flags_reg[fasm_pkg::GENERAL_SUMMARY_IRQ_POS];
            alarm_summary_reg <= fault_unmasked_irq;
        end
    end

    // Alarm is active low; an unloaded trim holds it whatever the masks say
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_n_reg <= 1'b0;
        end else if (ce_i) begin
            alarm_n_reg <= ~(fault_unmasked_alarm
                          | fault_flags_reg[fasm_pkg::TRIM_NOT_LOADED_POS]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    // Read data is registered; unmapped addresses answer zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_reg <= '0;
            reg_rvalid_reg <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_reg <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    fasm_pkg::FAULT_IRQ_MASK_OFS: begin
                        reg_rdata_reg <= fault_irq_mask_reg;
                    end
                    fasm_pkg::GENERAL_IRQ_MASK_OFS: begin
                        reg_rdata_reg <= general_irq_mask_reg;
                    end
                    fasm_pkg::FAULT_FLAGS_OFS: begin
                        reg_rdata_reg <= fault_flags_reg;
                    end
                    default: begin
                        reg_rdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    assign reg_rdata_o = reg_rdata_reg;
    assign reg_rvalid_o = reg_rvalid_reg;
    assign irq_o = irq_reg;
    assign alarm_n_o = alarm_n_reg;
    assign alarm_summary_o = alarm_summary_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence watchdog_read_gone_s;
        ce_i && fault_read && !watchdog_error_i;
    endsequence

    sequence watchdog_set_s;
        ce_i && watchdog_error_i;
    endsequence

    unmasked_irq_a: assert property (
        ce_i && fault_unmasked_irq |=> irq_o)
        else $error("unmasked fault did not raise irq");

    all_masked_a: assert property (
        ce_i && !fault_unmasked_irq && !fault_flags_reg[15] |=> !irq_o)
        else $error("irq raised with every flag masked");

    trim_alarm_a: assert property (
        ce_i && fault_flags_reg[9] |=> !alarm_n_o)
        else $error("alarm released while trim not loaded");

    osc_no_irq_a: assert property (
        ce_i && (fault_flags_reg & ~fault_irq_mask_reg & fasm_pkg::FAULT_IRQ_BITS) == 16'h0000
        && !fault_flags_reg[15] && fault_flags_reg[12] && !fault_irq_mask_reg[12]
        |=> !irq_o && !alarm_n_o)
        else $error("oscillator failure misrouted");

    sticky_keep_a: assert property (
        watchdog_set_s ##1 (ce_i && !fault_read)[*2] |=> fault_flags_reg[6])
        else $error("watchdog flag lost without a read");

    read_clear_a: assert property (
        watchdog_read_gone_s ##1 ce_i && !watchdog_error_i |=> !fault_flags_reg[6])
        else $error("sticky flag survived read after cause left");

    reference_follow_a: assert property (
        ce_i && force_reference_i |=> fault_flags_reg[5])
        else $error("reference force not shown");

    general_summary_a: assert property (
        ce_i && |(general_status_i & ~general_irq_mask_reg[7:0]) |=> fault_flags_reg[15])
        else $error("general summary bit missing");

    fault_summary_a: assert property (
        ce_i && fault_unmasked_irq |=> alarm_summary_o)
        else $error("fault summary missing");

    trim_stays_a: assert property (
        !fault_flags_reg[9] |=> !fault_flags_reg[9])
        else $error("trim flag returned");

    mask_reserved_a: assert property (
        (fault_irq_mask_reg & 16'hCE00) == 16'hCE00 && general_irq_mask_reg[15:8] == 8'hFF)
        else $error("reserved mask bits not one");

endmodule

/* File: verif/fasm_top_tb.sv */
module fasm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Offsets and flag positions of the level causes, in lv order
    localparam logic [5:0] FMS = fasm_pkg::FAULT_IRQ_MASK_OFS;
    localparam logic [5:0] GMS = fasm_pkg::GENERAL_IRQ_MASK_OFS;
    localparam logic [5:0] FLG = fasm_pkg::FAULT_FLAGS_OFS;
    localparam int POS [11] = '{13, 12, 4, 3, 2, 5, 1, 0, 5, 1, 0};

    // Stimulus, all driven from time zero
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [5:0] reg_addr_i = 6'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [10:0] lv = 11'h000;
    logic [2:0] sv = 3'h0;
    logic [3:0] cnt = 4'h0;
    logic lim8 = 1'b0;
    logic trim_done = 1'b0;
    logic [7:0] gs = 8'h00;
    logic [15:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic irq_o;
    logic alarm_n_o;
    logic alarm_summary_o;
    logic [15:0] exp_q [$];
    logic [15:0] lfsr = 16'h0045;
    int mismatches = 0;
    int checked = 0;

    // Free-running 250 MHz clock
    always #2 sys_clk_i = ~sys_clk_i;

    fasm_top dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .self_diag_fault_i(lv[0]), .oscillator_start_failure_i(lv[1]),
        .frame_check_count_i(cnt), .frame_check_limit_eight_i(lim8),
        .trim_load_done_i(trim_done), .trim_check_error_i(sv[0]),
        .frame_check_error_i(sv[1]), .watchdog_error_i(sv[2]),
        .input_one_limit_i(lv[2]), .input_zero_limit_i(lv[3]), .die_temp_limit_i(lv[4]),
        .reference_invalid_i(lv[5]), .overtemp_error_i(lv[6]), .overtemp_warning_i(lv[7]),
        .force_reference_i(lv[8]), .force_overtemp_error_i(lv[9]),
        .force_overtemp_warning_i(lv[10]), .general_status_i(gs),
        .irq_o(irq_o), .alarm_n_o(alarm_n_o), .alarm_summary_o(alarm_summary_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic report(input string msg);
        mismatches++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic close_out();
        if (exp_q.size() != 0) begin
            report("reads left unanswered");
        end
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Strobes last one cycle, so consecutive calls leave a low cycle between
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
    endtask

    task automatic check_lvl(input logic e_irq, input logic e_aln, input logic e_sum);
        checked++;
        if ({irq_o, alarm_n_o, alarm_summary_o} !== {e_irq, e_aln, e_sum}) begin
            report($sformatf("irq/alarm_n/summary %b%b%b, want %b%b%b",
                irq_o, alarm_n_o, alarm_summary_o, e_irq, e_aln, e_sum));
        end
    endtask

    // Read monitor: rvalid stands one cycle, looked at on the falling edge where it is settled
    always @(negedge sys_clk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                report("read data with no request");
            end else begin
                cmp_word(exp_q.pop_front());
            end
        end
    end

    task automatic cmp_word(input logic [15:0] e);
        checked++;
        if (reg_rdata_o !== e) begin
            report($sformatf("read %h, want %h", reg_rdata_o, e));
        end
    endtask

    // Watchdog far beyond the roughly six hundred cycles the tests need
    initial begin
        #50000;
        report("watchdog expired");
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] e;
        logic [15:0] w;
        logic b;
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        // Reset values; alarm stays active until trim memory is loaded
        rd(FMS, 16'hEFDF);
        rd(GMS, 16'hFFFF);
        rd(FLG, 16'h0200);
        rd(6'h15, 16'h0000);
        tick(2);
        check_lvl(1'b0, 1'b0, 1'b0);
        @(posedge sys_clk_i);
        trim_done <= 1'b1;
        @(posedge sys_clk_i);
        trim_done <= 1'b0;
        tick(6);
        check_lvl(1'b0, 1'b1, 1'b0);
        rd(FLG, 16'h0000);
        $display("test reset finished");
        // Reserved mask bits stay one; the flag word ignores writes
        wr(FMS, 16'h0000);
        rd(FMS, 16'hCE00);
        wr(GMS, 16'h0000);
        rd(GMS, 16'hFF30);
        wr(FLG, 16'hFFFF);
        rd(FLG, 16'h0000);
        wr(GMS, 16'hFFFF);
        wr(FMS, 16'hFFFF);
        $display("test masks finished");
        // Each level cause: flag set while masked, outputs only once unmasked
        for (int k = 0; k < 11; k++) begin
            e = 16'h0001 << POS[k];
            @(posedge sys_clk_i);
            lv[k] <= 1'b1;
            tick(8);
            rd(FLG, e);
            tick(2);
            check_lvl(1'b0, 1'b1, 1'b0);
            wr(FMS, 16'h0000);
            tick(3);
            check_lvl(k != 1, 1'b0, k != 1);
            @(posedge sys_clk_i);
            lv[k] <= 1'b0;
            tick(8);
            rd(FLG, 16'h0000);
            tick(1);
            check_lvl(1'b0, 1'b1, 1'b0);
            wr(FMS, 16'hFFFF);
        end
        $display("test level faults finished");
        // Sticky flags: a pulse survives until read; a held cause survives reads
        wr(FMS, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            e = 16'h0100 >> k;
            @(posedge sys_clk_i);
            sv[k] <= 1'b1;
            @(posedge sys_clk_i);
            sv[k] <= 1'b0;
            tick(4);
            check_lvl(1'b1, 1'b0, 1'b1);
            rd(FLG, e);
            rd(FLG, 16'h0000);
            tick(3);
            check_lvl(1'b0, 1'b1, 1'b0);
            @(posedge sys_clk_i);
            sv[k] <= 1'b1;
            tick(2);
            rd(FLG, e);
            rd(FLG, e);
            @(posedge sys_clk_i);
            sv[k] <= 1'b0;
            tick(2);
            rd(FLG, e);
            rd(FLG, 16'h0000);
            // A pulse just before a read must still be returned by that read
            @(posedge sys_clk_i);
            sv[k] <= 1'b1;
            fork
                rd(FLG, e);
                begin
                    @(posedge sys_clk_i);
                    sv[k] <= 1'b0;
                end
            join
            rd(FLG, 16'h0000);
        end
        wr(FMS, 16'hFFFF);
        $display("test sticky finished");
        // Counter view for both limit settings
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge sys_clk_i);
            cnt <= lfsr[3:0];
            lim8 <= i[0];
            tick(2);
            e = i[0] ? {4'h0, lfsr[2:1], 10'h000} : {4'h0, lfsr[1:0], 10'h000};
            rd(FLG, e);
        end
        @(posedge sys_clk_i);
        cnt <= 4'h0;
        $display("test counter finished");
        // General summary from random masks and status; it never feeds the alarm
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr;
            wr(GMS, w);
            lfsr = lfsr_next(lfsr);
            @(posedge sys_clk_i);
            gs <= lfsr[7:0];
            tick(4);
            e = (w & 16'h00CF) | 16'hFF30;
            b = |(lfsr[7:0] & ~e[7:0]);
            rd(GMS, e);
            rd(FLG, {b, 15'h0000});
            tick(3);
            check_lvl(b, 1'b1, 1'b0);
        end
        $display("test general summary finished");
        // A low clock enable freezes the masks against writes
        @(posedge sys_clk_i);
        ce <= 1'b0;
        wr(FMS, 16'h0000);
        ce <= 1'b1;
        rd(FMS, 16'hFFFF);
        $display("test clock enable finished");
        tick(4);
        close_out();
    end
endmodule
